/* File: core/gpx_port.sv */
// Eight-pin I/O port with Wishbone registers and external interrupts
//
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
module gpx_port (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // External pins, three signals each
   input wire logic [gpx_pkg::PIN_W-1:0] pad_in,
   output logic [gpx_pkg::PIN_W-1:0] pad_out,
   output logic [gpx_pkg::PIN_W-1:0] pad_oe_n,
   // On-chip peripheral alternate functions
   input wire logic [gpx_pkg::PIN_W-1:0] alt_en,
   input wire logic [gpx_pkg::PIN_W-1:0] alt_drive,
   input wire logic [gpx_pkg::PIN_W-1:0] alt_out,
   input wire logic [gpx_pkg::PIN_W-1:0] alt_push_pull,
   output logic [gpx_pkg::PIN_W-1:0] alt_in,
   // External interrupt vectors
   output logic [gpx_pkg::GRP_N-1:0] irq_req,
   input wire logic [gpx_pkg::GRP_N-1:0] vec_fetch
);
   import gpx_pkg::*;

   // Reset synchroniser stages
   logic rst_meta_reg;
   logic rst_n;
   // Pin input synchroniser stages
   logic [PIN_W-1:0] pin_meta_reg;
   logic [PIN_W-1:0] pin_lvl_reg;
   // Software registers
   logic [PIN_W-1:0] data_latch_reg;
   logic [PIN_W-1:0] direction_reg;
   logic [PIN_W-1:0] option_reg;
   logic [SENSE_W*GRP_N-1:0] sense_reg;
   // Bus decode
   logic bus_req; // Fresh access this cycle
   logic wr_go; // Write takes effect
   logic hit_data;
   logic hit_dir;
   logic hit_opt;
   logic hit_sense;
   logic hit_lvl;
   logic [SENSE_W*GRP_N-1:0] sense_next;
   // Pin behaviour
   logic [PIN_W-1:0] periph_drv; // Peripheral owns the output
   logic [PIN_W-1:0] out_mode; // Pin acts as output
   logic [PIN_W-1:0] out_val; // Level presented to the pad
   logic [PIN_W-1:0] push_pull; // Push-pull rather than open-drain
   logic [PIN_W-1:0] opt_eff; // Option bits that exist
   logic [PIN_W-1:0] read_val; // Data register read value
   logic [PIN_W-1:0] irq_en; // Pins enabled as interrupt sources
   logic [PIN_W-1:0] rd_mux;

   // Byte-lane write of an 8-bit register
   function automatic logic [7:0] lane_wr(input logic [7:0] old,
      input logic [7:0] dat, input logic sel0);
      lane_wr = sel0 ? dat : old;
   endfunction : lane_wr

   // Reset release through two flip-flops
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // Two-stage synchroniser for pad inputs
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_reg <= '0;
         pin_lvl_reg <= '0;
      end else begin
         pin_meta_reg <= pad_in;
         pin_lvl_reg <= pin_meta_reg;
      end
   end

   // Access decode, one aligned word per register
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_go = bus_req & wb_we_i;
   assign hit_data = (wb_adr_i == OFS_DATA_LATCH);
   assign hit_dir = (wb_adr_i == OFS_DIRECTION);
   assign hit_opt = (wb_adr_i == OFS_OPTION);
   assign hit_sense = (wb_adr_i == OFS_SENSE);
   assign hit_lvl = (wb_adr_i == OFS_PIN_LEVEL);

   // Acknowledge one cycle after the request, drop the next
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
      end
   end

   // Data latch: every write is stored, whatever the direction
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_latch_reg <= RST_DATA_LATCH;
      end else if (wr_go && hit_data) begin
         data_latch_reg <= lane_wr(data_latch_reg, wb_dat_i[7:0],
            wb_sel_i[0]);
      end
   end

   // Direction register, 0 input and 1 output
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         direction_reg <= RST_DIRECTION;
      end else if (wr_go && hit_dir) begin
         direction_reg <= lane_wr(direction_reg, wb_dat_i[7:0],
            wb_sel_i[0]);
      end
   end

   // Option register; missing bits stay zero
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         option_reg <= RST_OPTION;
      end else if (wr_go && hit_opt) begin
         option_reg <= lane_wr(option_reg, wb_dat_i[7:0],
            wb_sel_i[0]) & OPT_IMPL_MASK;
      end
   end

   // Sensitivity next value, two bits per group
   always_comb begin
      sense_next = sense_reg;
      if (wr_go && hit_sense && wb_sel_i[0]) begin
         sense_next = wb_dat_i[SENSE_W*GRP_N-1:0];
      end
   end

   // Sensitivity register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sense_reg <= RST_SENSE;
      end else begin
         sense_reg <= sense_next;
      end
   end

   // Only existing option bits count
   assign opt_eff = option_reg & OPT_IMPL_MASK;

   // Peripheral takes over pins it drives
   assign periph_drv = alt_en & alt_drive;
   assign out_mode = direction_reg | periph_drv;

   // Choose pad level and drive style per pin
   always_comb begin
      for (int i = 0; i < PIN_W; i++) begin
         if (periph_drv[i]) begin
            out_val[i] = alt_out[i];
            push_pull[i] = alt_push_pull[i];
         end else begin
            out_val[i] = data_latch_reg[i];
            push_pull[i] = opt_eff[i];
         end
      end
   end

   // Register pad drive; open-drain releases a high level
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pad_out <= '0;
         pad_oe_n <= '1;
      end else begin
         pad_out <= out_val;
         pad_oe_n <= ~(out_mode & (push_pull | ~out_val));
      end
   end

   // Peripheral input: latch when output, pin when input
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         alt_in <= '0;
      end else begin
         alt_in <= (direction_reg & data_latch_reg)
            | (~direction_reg & pin_lvl_reg);
      end
   end

   // Data read value per pin
   always_comb begin
      for (int i = 0; i < PIN_W; i++) begin
         if (direction_reg[i]) begin
            read_val[i] = data_latch_reg[i];
         end else if (periph_drv[i]) begin
            read_val[i] = alt_out[i];
         end else begin
            read_val[i] = pin_lvl_reg[i];
         end
      end
   end

   // Read multiplexer; unmapped offsets read zero
   always_comb begin
      if (hit_data) begin
         rd_mux = read_val;
      end else if (hit_dir) begin
         rd_mux = direction_reg;
      end else if (hit_opt) begin
         rd_mux = opt_eff;
      end else if (hit_sense) begin
         rd_mux = {{(PIN_W-SENSE_W*GRP_N){1'b0}}, sense_reg};
      end else if (hit_lvl) begin
         rd_mux = pin_lvl_reg;
      end else begin
         rd_mux = '0;
      end
   end

   // Read data captured with the acknowledge
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_dat_o <= '0;
      end else if (bus_req && !wb_we_i) begin
         wb_dat_o <= {24'h000000, rd_mux};
      end
   end

   // Interrupt sources: input pins with option set, no peripheral
   assign irq_en = ~direction_reg & opt_eff & ~alt_en;

   // One request latch per fixed pin group
   for (genvar g = 0; g < GRP_N; g++) begin : g_grp
      gpx_irq_if irq ();
      assign irq.pin_lvl = pin_lvl_reg[g*GRP_W +: GRP_W];
      assign irq.pin_en = irq_en[g*GRP_W +: GRP_W];
      assign irq.sense = gpx_sense_t'(sense_reg[g*SENSE_W +: SENSE_W]);
      assign irq.sense_chg = (sense_next[g*SENSE_W +: SENSE_W]
         != sense_reg[g*SENSE_W +: SENSE_W]);
      assign irq.vec_fetch = vec_fetch[g];
      assign irq_req[g] = irq.req;
      gpx_irq_group u_grp (
         .core_clk(core_clk),
         .rst_n(rst_n),
         .irq(irq.grp)
      );
   end
endmodule : gpx_port

/* File: core/gpx_pkg.sv */
// Constants and types shared by the I/O port design files
// Notes on behaviour
// - Interrupt-input pin events raise external requests
// - Per-group sensitivity held in sensitivity register
// - Each vector serves a fixed pin group
// - Enabled group pins are NAND combined
// - Hidden request latch clears on vector fetch
// - Changing sensitivity bits discards pending request
// - Output pin: write drives pin, read returns latch
// - Push-pull drives both levels, open-drain floats one
// - Latch writes always stored, even as input
// - Read gives latch for outputs, pin for inputs
// - Direction bit: 0 input, 1 output, reset 00h
// - Option bit selects interrupt or push-pull, reset 00h
// - Pins lacking option bit: direction alone decides
// - Active peripheral overrides direction and option
// - Peripheral-driven pin forced to output mode
// - Input pin with peripheral output reads peripheral
// - Output pin feeds latch level to peripheral input
// - Register bit n controls pin n
package gpx_pkg;
   // Port and group geometry
   localparam int PIN_W = 8;
   localparam int GRP_W = 4;
   localparam int GRP_N = 2;
   // Register byte offsets on the bus
   localparam logic [7:0] OFS_DATA_LATCH = 8'h00;
   localparam logic [7:0] OFS_DIRECTION = 8'h04;
   localparam logic [7:0] OFS_OPTION = 8'h08;
   localparam logic [7:0] OFS_SENSE = 8'h0C;
   localparam logic [7:0] OFS_PIN_LEVEL = 8'h10;
   // Values after reset
   localparam logic [7:0] RST_DATA_LATCH = 8'h00;
   localparam logic [7:0] RST_DIRECTION = 8'h00;
   localparam logic [7:0] RST_OPTION = 8'h00;
   localparam logic [3:0] RST_SENSE = 4'h0;
   // Pins that have an option bit (bits 5:4 are open-drain only)
   localparam logic [7:0] OPT_IMPL_MASK = 8'hCF;
   // Sensitivity field width per group
   localparam int SENSE_W = 2;
   // Sensitivity encodings, named for the pin edge or level, the inverse of the group's combined signal
   typedef enum logic [1:0] {
      GPX_SENSE_FALL_LOW = 2'h0,
      GPX_SENSE_RISE = 2'h1,
      GPX_SENSE_FALL = 2'h2,
      GPX_SENSE_BOTH = 2'h3
   } gpx_sense_t;
endpackage : gpx_pkg

/* File: core/gpx_irq_if.sv */
// Signals between the port core and one interrupt group
`timescale 1ns/100ps
interface gpx_irq_if;
   import gpx_pkg::*;
   logic [GRP_W-1:0] pin_lvl; // Synchronised pin levels
   logic [GRP_W-1:0] pin_en; // Pins enabled as interrupt sources
   gpx_sense_t sense; // Selected sensitivity
   logic sense_chg; // Pulse: sensitivity bits modified
   logic vec_fetch; // Pulse: CPU fetched this vector
   logic req; // Pending request toward the CPU
   // Core side drives the group inputs
   modport core (output pin_lvl, output pin_en, output sense,
      output sense_chg, output vec_fetch, input req);
   // Group side returns the request
   modport grp (input pin_lvl, input pin_en, input sense,
      input sense_chg, input vec_fetch, output req);
endinterface : gpx_irq_if

/* File: core/gpx_irq_group.sv */
// One external interrupt group: NAND combine and request latch
`timescale 1ns/100ps
module gpx_irq_group (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Link to the port core
   gpx_irq_if.grp irq
);
   import gpx_pkg::*;

   logic comb_sig; // Combined group signal
   logic comb_prev_reg; // Previous combined value
   logic event_hit; // Selected event seen this cycle
   logic req_reg; // Hidden request latch

   // Any enabled pin low drives the combined signal high
   assign comb_sig = ~&(irq.pin_lvl | ~irq.pin_en);

   // Remember last combined value for edge detection
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         comb_prev_reg <= 1'b0;
      end else begin
         comb_prev_reg <= comb_sig;
      end
   end

   // Event decode per sensitivity
   always_comb begin
      case (irq.sense)
         GPX_SENSE_FALL_LOW: event_hit = comb_sig;
         GPX_SENSE_RISE: event_hit = ~comb_sig & comb_prev_reg;
         GPX_SENSE_FALL: event_hit = comb_sig & ~comb_prev_reg;
         GPX_SENSE_BOTH: event_hit = comb_sig ^ comb_prev_reg;
         default: event_hit = 1'b0;
      endcase
   end

   // Request latch: event set wins over fetch or sense clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_reg <= 1'b0;
      end else if (event_hit) begin
         req_reg <= 1'b1;
      end else if (irq.vec_fetch || irq.sense_chg) begin
         req_reg <= 1'b0;
      end
   end

   assign irq.req = req_reg;
endmodule : gpx_irq_group

/* File: tb/gpx_port_chk.sv */
// Concurrent checks on the I/O port top-level ports
`timescale 1ns/100ps
module gpx_port_chk (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Pins and peripherals
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe_n,
   input wire logic [7:0] alt_en,
   input wire logic [7:0] alt_drive,
   input wire logic [7:0] alt_out,
   input wire logic [7:0] alt_push_pull,
   input wire logic [1:0] irq_req
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // Bus answers one cycle after a fresh request
   a_ack_follows_req: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
   a_ack_one_cycle: assert property (
      wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_ack_has_cause: assert property (
      $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
   a_rdata_upper_zero: assert property (
      wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data set");
   // Pins float and requests are quiet as reset ends
   a_reset_safe: assert property (
      $rose(reset_n) |-> pad_oe_n == 8'hFF && irq_req == 2'h0)
      else $error("pins driven at reset");
   // Peripheral drive takes the pin over
   a_alt_pp_drive: assert property (
      ((pad_oe_n | (pad_out ^ $past(alt_out))) &
      $past(alt_en & alt_drive & alt_push_pull)) == 8'h00)
      else $error("push-pull drive lost");
   a_alt_od_drive: assert property (
      ((pad_oe_n ^ $past(alt_out)) &
      $past(alt_en & alt_drive & ~alt_push_pull)) == 8'h00)
      else $error("open-drain drive lost");
   // Option-less pins never drive high unless a peripheral is enabled on them
   a_od_pins_low: assert property (
      ((~pad_oe_n & pad_out & ~$past(alt_en)) & 8'h30) == 8'h00)
      else $error("open-drain pin high");
   // Main scenarios
   c_irq0: cover property ($rose(irq_req[0]));
   c_irq1: cover property ($rose(irq_req[1]));
   c_drive: cover property ($fell(pad_oe_n[0]));
endmodule : gpx_port_chk
bind gpx_port gpx_port_chk u_chk (.*);

/* File: tb/gpx_pin_model.sv */
// Pin partner: outside drivers and a floating-line model
`timescale 1ns/100ps
module gpx_pin_model (
   // Clock
   input wire logic core_clk,
   // Port side
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe_n,
   // Outside drivers
   input wire logic [7:0] ext_drv,
   input wire logic [7:0] ext_lvl,
   // Resolved level
   output logic [7:0] pad_in
);
   logic [7:0] flt_reg = 8'h00; // Undriven lines never read stable
   // Wander every cycle
   always_ff @(posedge core_clk) begin
      flt_reg <= ~flt_reg;
   end
   // Port drive, then outside drive, else wandering level
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!pad_oe_n[i]) begin
            pad_in[i] = pad_out[i];
         end else if (ext_drv[i]) begin
            pad_in[i] = ext_lvl[i];
         end else begin
            pad_in[i] = flt_reg[i];
         end
      end
   end
endmodule : gpx_pin_model

/* File: tb/test_gpx_port.sv */
// Self-checking bench for the I/O port
`timescale 1ns/100ps
module test_gpx_port;
   import gpx_pkg::*;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat, q;
   logic ack;
   logic [7:0] pad_in, pad_out, pad_oe_n, alt_in;
   logic [7:0] ext_drv = 8'hFF;
   logic [7:0] ext_lvl = 8'h00;
   logic [7:0] a_en = 8'h00;
   logic [7:0] a_drv = 8'h00;
   logic [7:0] a_out = 8'h00;
   logic [7:0] a_pp = 8'h00;
   logic [1:0] irq;
   logic [1:0] vf = 2'h0;
   logic [7:0] ofs [4] = '{OFS_DATA_LATCH, OFS_DIRECTION, OFS_OPTION,
      OFS_SENSE};
   int n_fail = 0;
   int n_compared = 0;
   always #10 core_clk = ~core_clk;
   gpx_port uut (.core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe_n(pad_oe_n), .alt_en(a_en),
      .alt_drive(a_drv), .alt_out(a_out), .alt_push_pull(a_pp),
      .alt_in(alt_in), .irq_req(irq), .vec_fetch(vf));
   gpx_pin_model u_pins (.core_clk(core_clk), .pad_out(pad_out),
      .pad_oe_n(pad_oe_n), .ext_drv(ext_drv), .ext_lvl(ext_lvl),
      .pad_in(pad_in));
   // Counts and verdict
   task end_of_test;
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test
   task chk(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // One classic Wishbone cycle; read data lands in q
   task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      int k;
      @(posedge core_clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (ack !== 1'b1 && k < 16);
      if (ack !== 1'b1) begin
         n_fail++;
         end_of_test;
      end
      q = rdat;
      cyc <= 1'b0;
      @(posedge core_clk);
   endtask : acc
   // Bounded wait for a request level
   task wait_irq(input int i, input logic v);
      int k;
      k = 0;
      while (irq[i] !== v && k < 12) begin
         @(posedge core_clk);
         k++;
      end
      chk(irq[i], v, "irq_req");
      if (k == 12) end_of_test;
   endtask : wait_irq
   task fetch(input logic [1:0] m);
      vf <= m;
      @(posedge core_clk);
      vf <= 2'h0;
   endtask : fetch
   initial begin
      repeat (4) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      foreach (ofs[i]) begin
         acc(1'b0, ofs[i], 8'h00);
         chk(q, 32'h0, "reset value");
      end
      acc(1'b0, 8'h40, 8'h00);
      chk(q, 32'h0, "unmapped");
      $display("reset test done");
      ext_lvl <= 8'h3C;
      acc(1'b1, OFS_DATA_LATCH, 8'hA5);
      acc(1'b0, OFS_DATA_LATCH, 8'h00);
      chk(q, 32'h3C, "input read");
      ext_drv <= 8'h00;
      acc(1'b1, OFS_DIRECTION, 8'hFF);
      acc(1'b1, OFS_OPTION, 8'hFF);
      acc(1'b0, OFS_OPTION, 8'h00);
      chk(q, 32'hCF, "option");
      acc(1'b0, OFS_DATA_LATCH, 8'h00);
      chk(q, 32'hA5, "output read");
      chk(pad_oe_n, 8'h20, "pad_oe_n");
      chk(pad_out & ~pad_oe_n, 8'h85, "pad_out");
      acc(1'b1, OFS_OPTION, 8'h00);
      acc(1'b0, OFS_PIN_LEVEL, 8'h00);
      chk(pad_oe_n, 8'hA5, "open drain");
      chk(pad_out & ~pad_oe_n, 8'h00, "open drain low");
      $display("output test done");
      acc(1'b1, OFS_DIRECTION, 8'h00);
      ext_drv <= 8'hF8;
      ext_lvl <= 8'h00;
      a_en <= 8'h07;
      a_drv <= 8'h05;
      a_out <= 8'h01;
      a_pp <= 8'h01;
      acc(1'b0, OFS_DATA_LATCH, 8'h00);
      chk(q & 32'h1, 32'h1, "alt read");
      chk(pad_oe_n & 8'h07, 8'h02, "alt oe");
      chk(pad_out[0], 1'b1, "alt out");
      acc(1'b1, OFS_DATA_LATCH, 8'h02);
      acc(1'b1, OFS_DIRECTION, 8'h02);
      acc(1'b0, OFS_PIN_LEVEL, 8'h00);
      chk(alt_in[1], 1'b1, "alt_in");
      a_en <= 8'h00;
      ext_drv <= 8'hFF;
      ext_lvl <= 8'hFF;
      acc(1'b1, OFS_DIRECTION, 8'h00);
      $display("alternate test done");
      acc(1'b1, OFS_OPTION, 8'h01);
      acc(1'b1, OFS_SENSE, 8'h02);
      ext_lvl[0] <= 1'b0;
      wait_irq(0, 1'b1);
      chk(irq[1], 1'b0, "group1");
      fetch(2'h1);
      wait_irq(0, 1'b0);
      ext_lvl[0] <= 1'b1;
      repeat (4) @(posedge core_clk);
      ext_lvl[0] <= 1'b0;
      wait_irq(0, 1'b1);
      acc(1'b1, OFS_SENSE, 8'h01);
      wait_irq(0, 1'b0);
      ext_lvl <= 8'hFD;
      acc(1'b1, OFS_SENSE, 8'h02);
      acc(1'b1, OFS_OPTION, 8'h03);
      wait_irq(0, 1'b1);
      fetch(2'h1);
      wait_irq(0, 1'b0);
      ext_lvl[0] <= 1'b0;
      repeat (8) @(posedge core_clk);
      chk(irq[0], 1'b0, "masked");
      ext_lvl <= 8'hFF;
      acc(1'b1, OFS_OPTION, 8'h43);
      acc(1'b1, OFS_SENSE, 8'h0A);
      ext_lvl[6] <= 1'b0;
      wait_irq(1, 1'b1);
      chk(irq[0], 1'b0, "group0");
      // Group 1 on both edges, then on level
      acc(1'b1, OFS_SENSE, 8'h0E);
      wait_irq(1, 1'b0);
      ext_lvl[6] <= 1'b1;
      wait_irq(1, 1'b1);
      fetch(2'h2);
      wait_irq(1, 1'b0);
      acc(1'b1, OFS_SENSE, 8'h02);
      ext_lvl[6] <= 1'b0;
      wait_irq(1, 1'b1);
      fetch(2'h2);
      repeat (2) @(posedge core_clk);
      chk(irq[1], 1'b1, "level hold");
      $display("interrupt test done");
      end_of_test;
   end
endmodule : test_gpx_port
